// ### include/rtcs_defs.vh
/*
 * shared constants of the two-wire slave register port.
 * assumes inclusion by bare name from the design files under verilog/.
 */
`ifndef RTCS_DEFS_VH
`define RTCS_DEFS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RTCS_CLK_KHZ     20000
`define RTCS_TOUT_MS     950

// ----------------------------------------------------------------
// byte framing
// ----------------------------------------------------------------
`define RTCS_BYTE_BITS   4'h8
`define RTCS_LAST_BIT    4'h7
`define RTCS_BIT_ZERO    4'h0
`define RTCS_BIT_STEP    4'h1
`define RTCS_DIR_RD      1'b1

// ----------------------------------------------------------------
// register pointer
// ----------------------------------------------------------------
`define RTCS_PTR_RST     8'h00
`define RTCS_PTR_STEP    8'h01
`define RTCS_NIB_STEP    4'h1
`define RTCS_GRP_LO      4'h1
`define RTCS_GRP_HI      4'h3

// ----------------------------------------------------------------
// defaults
// ----------------------------------------------------------------
`define RTCS_SLV_ADDR    7'h5A
`define RTCS_FIFO_DEPTH  8
`define RTCS_FIFO_AW     3
`define RTCS_WR_W        16

`endif

// ### verilog/rtcs_fifo.v
/*
 * small synchronous fifo with a registered output stage.
 * assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ns
`default_nettype none

module rtcs_fifo #(
    parameter W     = 16,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire         sys_clk_i,
    input  wire         rst_i,
    input  wire         in_valid_i,
    output wire         in_ready_o,
    input  wire [W-1:0] in_data_i,
    output wire         out_valid_o,
    input  wire         out_ready_i,
    output wire [W-1:0] out_data_o
);

    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0]   count_reg;
    reg          out_valid_reg;
    reg [W-1:0]  out_data_reg;

    wire [AW:0] depth_w = DEPTH[AW:0];
    wire        full    = (count_reg == depth_w);
    wire        empty   = (count_reg == {(AW+1){1'b0}});
    wire        push    = in_valid_i & ~full;
    // refill the output stage whenever it is free or being taken
    wire        pop     = ~empty & (~out_valid_reg | out_ready_i);

    assign in_ready_o  = ~full;
    assign out_valid_o = out_valid_reg;
    assign out_data_o  = out_data_reg;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    always @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    // ----------------------------------------------------------------
    // pointers and output stage
    // ----------------------------------------------------------------
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_reg    <= {AW{1'b0}};
            rd_ptr_reg    <= {AW{1'b0}};
            count_reg     <= {(AW+1){1'b0}};
            out_valid_reg <= 1'b0;
            out_data_reg  <= {W{1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_reg   <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
                out_data_reg <= mem[rd_ptr_reg];
            end
            if (push & ~pop) begin
                count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
            end else if (pop & ~push) begin
                count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
            end
            if (pop) begin
                out_valid_reg <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_reg <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// ### verilog/rtcs_i2c_slave.v
/*
 * two-wire serial slave port giving a bus master byte access to a
 * register space. writes leave through a fifo as address/data pairs,
 * reads fetch a byte from rd_data_i at the address on rd_addr_o.
 * assumes open-drain pads outside, pull-ups on both lines, and a
 * register file that answers rd_data_i combinationally on sys_clk_i.
 */
`timescale 1ns/1ns
`default_nettype none
`include "rtcs_defs.vh"

module rtcs_i2c_slave #(
    parameter [6:0]  SLV_ADDR    = `RTCS_SLV_ADDR,
    parameter [31:0] TIMEOUT_CYC = `RTCS_TOUT_MS * `RTCS_CLK_KHZ,
    parameter        FIFO_DEPTH  = `RTCS_FIFO_DEPTH,
    parameter        FIFO_AW     = `RTCS_FIFO_AW
) (
    input  wire       sys_clk_i,
    input  wire       rst_i,
    input  wire       scl_i,
    output wire       scl_o,
    output wire       scl_oe_o,
    input  wire       sda_i,
    output wire       sda_o,
    output wire       sda_oe_o,
    output wire [7:0] rd_addr_o,
    input  wire [7:0] rd_data_i,
    output wire       rd_strobe_o,
    output wire       wr_valid_o,
    input  wire       wr_ready_i,
    output wire [7:0] wr_addr_o,
    output wire [7:0] wr_data_o,
    output wire       busy_o
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [7:0] S_IDLE = 8'h01;
    localparam [7:0] S_DEV  = 8'h02;
    localparam [7:0] S_DACK = 8'h04;
    localparam [7:0] S_SUB  = 8'h08;
    localparam [7:0] S_WR   = 8'h10;
    localparam [7:0] S_WACK = 8'h20;
    localparam [7:0] S_TX   = 8'h40;
    localparam [7:0] S_TACK = 8'h80;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    reg scl_s1_reg;
    reg scl_s2_reg;
    reg scl_d_reg;
    reg sda_s1_reg;
    reg sda_s2_reg;
    reg sda_d_reg;

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_d_reg  <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_d_reg  <= 1'b1;
        end else begin
            scl_s1_reg <= scl_i;
            scl_s2_reg <= scl_s1_reg;
            scl_d_reg  <= scl_s2_reg;
            sda_s1_reg <= sda_i;
            sda_s2_reg <= sda_s1_reg;
            sda_d_reg  <= sda_s2_reg;
        end
    end

    wire scl_rise = scl_s2_reg & ~scl_d_reg;
    wire scl_fall = ~scl_s2_reg & scl_d_reg;
    wire scl_high = scl_s2_reg & scl_d_reg;
    wire start_det = scl_high & sda_d_reg & ~sda_s2_reg;
    wire stop_det  = scl_high & ~sda_d_reg & sda_s2_reg;

    // ----------------------------------------------------------------
    // pointer step
    // ----------------------------------------------------------------
    function [7:0] ptr_inc;
        input [7:0] p;
        begin
            if (p[7:4] >= `RTCS_GRP_LO && p[7:4] <= `RTCS_GRP_HI) begin
                ptr_inc = {p[7:4], p[3:0] + `RTCS_NIB_STEP};
            end else begin
                ptr_inc = p + `RTCS_PTR_STEP;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg [7:0]  state_reg;
    reg [7:0]  state_next;
    reg [3:0]  bit_cnt_reg;
    reg [3:0]  bit_cnt_next;
    reg [7:0]  shift_reg;
    reg [7:0]  shift_next;
    reg [7:0]  ptr_reg;
    reg [7:0]  ptr_next;
    reg        dir_reg;
    reg        dir_next;
    reg        sda_oe_reg;
    reg        sda_oe_next;
    reg        scl_oe_reg;
    reg        scl_oe_next;
    reg        busy_reg;
    reg        busy_next;
    reg [31:0] tout_cnt_reg;
    reg [31:0] tout_cnt_next;
    reg        rd_strobe_reg;
    reg        rd_strobe_next;
    reg        push_req;

    wire fifo_in_ready;
    wire tout_hit = busy_reg & (tout_cnt_reg >= TIMEOUT_CYC);
    wire byte_done = (bit_cnt_reg == `RTCS_BYTE_BITS);

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always @* begin
        state_next     = state_reg;
        bit_cnt_next   = bit_cnt_reg;
        shift_next     = shift_reg;
        ptr_next       = ptr_reg;
        dir_next       = dir_reg;
        sda_oe_next    = sda_oe_reg;
        scl_oe_next    = scl_oe_reg;
        busy_next      = busy_reg;
        tout_cnt_next  = busy_reg ? tout_cnt_reg + 32'h1 : 32'h0;
        rd_strobe_next = 1'b0;
        push_req       = 1'b0;
        if (stop_det || tout_hit) begin
            // pointer is left alone so a later bare read continues
            state_next    = S_IDLE;
            sda_oe_next   = 1'b0;
            scl_oe_next   = 1'b0;
            busy_next     = 1'b0;
            tout_cnt_next = 32'h0;
        end else if (start_det) begin
            state_next    = S_DEV;
            bit_cnt_next  = `RTCS_BIT_ZERO;
            sda_oe_next   = 1'b0;
            scl_oe_next   = 1'b0;
            busy_next     = 1'b1;
            tout_cnt_next = 32'h0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    sda_oe_next = 1'b0;
                    scl_oe_next = 1'b0;
                end
                S_DEV, S_SUB, S_WR: begin
                    if (!byte_done) begin
                        if (scl_rise) begin
                            shift_next   = {shift_reg[6:0], sda_s2_reg};
                            bit_cnt_next = bit_cnt_reg + `RTCS_BIT_STEP;
                        end
                    end else if (scl_fall || scl_oe_reg) begin
                        if (state_reg == S_DEV) begin
                            bit_cnt_next = `RTCS_BIT_ZERO;
                            if (shift_reg[7:1] == SLV_ADDR) begin
                                state_next  = S_DACK;
                                dir_next    = shift_reg[0];
                                sda_oe_next = 1'b1;
                            end else begin
                                state_next = S_IDLE;
                            end
                        end else if (state_reg == S_SUB) begin
                            ptr_next     = shift_reg;
                            state_next   = S_WACK;
                            sda_oe_next  = 1'b1;
                            bit_cnt_next = `RTCS_BIT_ZERO;
                        end else begin
                            push_req = 1'b1;
                            if (fifo_in_ready) begin
                                ptr_next     = ptr_inc(ptr_reg);
                                state_next   = S_WACK;
                                sda_oe_next  = 1'b1;
                                // a stretch ends a cycle after the ack settles
                                bit_cnt_next = `RTCS_BIT_ZERO;
                            end else begin
                                // stretch the clock rather than drop a byte
                                scl_oe_next = 1'b1;
                            end
                        end
                    end
                end
                S_DACK: begin
                    if (scl_fall) begin
                        bit_cnt_next = `RTCS_BIT_ZERO;
                        if (dir_reg == `RTCS_DIR_RD) begin
                            state_next     = S_TX;
                            shift_next     = rd_data_i;
                            sda_oe_next    = ~rd_data_i[7];
                            rd_strobe_next = 1'b1;
                        end else begin
                            state_next  = S_SUB;
                            sda_oe_next = 1'b0;
                        end
                    end
                end
                S_WACK: begin
                    scl_oe_next = 1'b0;
                    if (scl_fall) begin
                        state_next  = S_WR;
                        sda_oe_next = 1'b0;
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_reg == `RTCS_LAST_BIT) begin
                            state_next   = S_TACK;
                            sda_oe_next  = 1'b0;
                            ptr_next     = ptr_inc(ptr_reg);
                            bit_cnt_next = `RTCS_BIT_ZERO;
                        end else begin
                            shift_next   = {shift_reg[6:0], 1'b0};
                            sda_oe_next  = ~shift_reg[6];
                            bit_cnt_next = bit_cnt_reg + `RTCS_BIT_STEP;
                        end
                    end
                end
                S_TACK: begin
                    if (scl_rise) begin
                        if (sda_s2_reg) begin
                            state_next = S_IDLE;
                        end else begin
                            bit_cnt_next = `RTCS_BYTE_BITS;
                        end
                    end else if (scl_fall && byte_done) begin
                        state_next     = S_TX;
                        shift_next     = rd_data_i;
                        sda_oe_next    = ~rd_data_i[7];
                        rd_strobe_next = 1'b1;
                        bit_cnt_next   = `RTCS_BIT_ZERO;
                    end
                end
                default: begin
                    state_next  = S_IDLE;
                    sda_oe_next = 1'b0;
                    scl_oe_next = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg     <= S_IDLE;
            bit_cnt_reg   <= `RTCS_BIT_ZERO;
            shift_reg     <= `RTCS_PTR_RST;
            ptr_reg       <= `RTCS_PTR_RST;
            dir_reg       <= 1'b0;
            sda_oe_reg    <= 1'b0;
            scl_oe_reg    <= 1'b0;
            busy_reg      <= 1'b0;
            tout_cnt_reg  <= 32'h0;
            rd_strobe_reg <= 1'b0;
        end else begin
            state_reg     <= state_next;
            bit_cnt_reg   <= bit_cnt_next;
            shift_reg     <= shift_next;
            ptr_reg       <= ptr_next;
            dir_reg       <= dir_next;
            sda_oe_reg    <= sda_oe_next;
            scl_oe_reg    <= scl_oe_next;
            busy_reg      <= busy_next;
            tout_cnt_reg  <= tout_cnt_next;
            rd_strobe_reg <= rd_strobe_next;
        end
    end

    // ----------------------------------------------------------------
    // write path
    // ----------------------------------------------------------------
    wire [`RTCS_WR_W-1:0] fifo_out_data;

    rtcs_fifo #(
        .W     (`RTCS_WR_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_wr_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push_req),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   ({ptr_reg, shift_reg}),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i),
        .out_data_o  (fifo_out_data)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // lines are only ever pulled low, never driven high
    assign scl_o       = 1'b0;
    assign sda_o       = 1'b0;
    assign scl_oe_o    = scl_oe_reg;
    assign sda_oe_o    = sda_oe_reg;
    assign rd_addr_o   = ptr_reg;
    assign rd_strobe_o = rd_strobe_reg;
    assign wr_addr_o   = fifo_out_data[15:8];
    assign wr_data_o   = fifo_out_data[7:0];
    assign busy_o      = busy_reg;

endmodule

`default_nettype wire

// ### test/rtcs_i2c_slave_properties.sv
/*
 * concurrent checks on the ports of the two-wire slave register port.
 * assumes it is bound into rtcs_i2c_slave and sees only its ports.
 */
`timescale 1ns/1ns
`default_nettype none
module rtcs_i2c_slave_checker #(
    parameter [31:0] TIMEOUT_CYC = 32'd19000000
) (
    input wire       sys_clk_i,
    input wire       rst_i,
    input wire       scl_i,
    input wire       scl_o,
    input wire       scl_oe_o,
    input wire       sda_i,
    input wire       sda_o,
    input wire       sda_oe_o,
    input wire [7:0] rd_addr_o,
    input wire [7:0] rd_data_i,
    input wire       rd_strobe_o,
    input wire       wr_valid_o,
    input wire       wr_ready_i,
    input wire [7:0] wr_addr_o,
    input wire [7:0] wr_data_o,
    input wire       busy_o
);
    // ----------------------------------------------------------------
    // own view of the bus
    // ----------------------------------------------------------------
    logic [1:0]  scl_sync_reg;
    logic [2:0]  sda_sync_reg;
    logic [31:0] open_cnt_reg;
    logic        start_w;
    logic        stop_w;
    assign start_w = scl_sync_reg[1] & sda_sync_reg[2] & ~sda_sync_reg[1];
    assign stop_w  = scl_sync_reg[1] & ~sda_sync_reg[2] & sda_sync_reg[1];
    // a start restarts the count, so a long run of restarts never fires
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 3'h7;
            open_cnt_reg <= 32'h0;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
            if (!busy_o || start_w) begin
                open_cnt_reg <= 32'h0;
            end else begin
                open_cnt_reg <= open_cnt_reg + 32'h1;
            end
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_drive_only_low: assert property (!scl_o && !sda_o)
        else $error("drive value of a line is not low");
    a_idle_lines_free: assert property (!busy_o |-> !scl_oe_o && !sda_oe_o)
        else $error("line held low while idle");
    a_start_sets_busy: assert property (start_w |-> ##[0:4] busy_o)
        else $error("start not followed by busy");
    a_restart_keeps: assert property (busy_o && start_w |=> busy_o [*4])
        else $error("repeated start dropped busy");
    a_stop_ends_busy: assert property (stop_w |-> ##[0:4] !busy_o)
        else $error("stop did not end the transaction");
    a_open_time_cap: assert property (open_cnt_reg <= TIMEOUT_CYC + 32'd8)
        else $error("transaction outlived the bus timeout");
    a_data_clock_low: assert property ($changed(sda_oe_o) |-> !scl_sync_reg[1])
        else $error("data drive changed while clock high");
    a_stretch_full: assert property (scl_oe_o |-> wr_valid_o)
        else $error("clock stretched with room in the buffer");
    a_pair_holds: assert property (wr_valid_o && !wr_ready_i |=>
        wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o))
        else $error("write pair changed before it was taken");
    a_strobe_pulse: assert property (rd_strobe_o |-> busy_o ##1 !rd_strobe_o)
        else $error("read strobe outside a transfer or too long");
endmodule

bind rtcs_i2c_slave rtcs_i2c_slave_checker #(.TIMEOUT_CYC(TIMEOUT_CYC))
    rtcs_i2c_slave_checker_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .rd_addr_o(rd_addr_o),
    .rd_data_i(rd_data_i), .rd_strobe_o(rd_strobe_o),
    .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
    .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .busy_o(busy_o));
`default_nettype wire

// ### test/rtcs_master_model.sv
/*
 * behavioural two-wire bus master driving open-drain enables.
 * assumes pull-ups on both lines and a 400 ns bit period.
 */
`timescale 1ns/1ns
`default_nettype none
module rtcs_master_model (
    input  wire logic sys_clk_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output var  logic scl_oe_o,
    output var  logic sda_oe_o
);
    int stuck = 0;
    // lines released when idle, only ever pulled low
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end
    task automatic q();
        repeat (2) @(negedge sys_clk_i);
    endtask
    // wait out a stretch, but never for ever
    task automatic rise();
        int n;
        n = 0;
        scl_oe_o = 1'b0;
        while (!scl_i && n < 4000) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (!scl_i) stuck++;
    endtask
    task automatic start();
        q();
        sda_oe_o = 1'b0;
        q();
        rise();
        q();
        sda_oe_o = 1'b1;
        q();
        scl_oe_o = 1'b1;
        q();
    endtask
    task automatic stop();
        sda_oe_o = 1'b1;
        q();
        rise();
        q();
        sda_oe_o = 1'b0;
        q();
        q();
    endtask
    // data only moves while the clock is low
    task automatic bit_io(input logic b, output logic r);
        sda_oe_o = !b;
        q();
        rise();
        q();
        r = sda_i;
        q();
        scl_oe_o = 1'b1;
        q();
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic get(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!more, r);
    endtask
endmodule
`default_nettype wire

// ### test/rtc_i2c_slave_register_port_tb_top.sv
/*
 * self-checking bench: master model, register file model, write consumer.
 * assumes the design and the master model are compiled before it.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    failures++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module rtc_i2c_slave_register_port_tb_top;
    localparam [6:0]  SLV  = 7'h5A;
    localparam [31:0] TOUT = 32'd8000;
    logic       sys_clk  = 1'b0;
    logic       rst      = 1'b1;
    logic       wr_ready = 1'b0;
    logic       hold     = 1'b0;
    logic       stretched = 1'b0;
    logic [7:0] mem [256];
    wire        m_scl_oe, m_sda_oe, s_scl_oe, s_sda_oe, scl_line, sda_line;
    wire        rd_strobe, wr_valid, busy;
    wire  [7:0] rd_addr, wr_addr, wr_data, rd_data;
    logic [15:0] exp_q [$];
    int         failures = 0;
    int         n_compared = 0;
    int         ptr = 0;
    int         n_strobe = 0;
    logic       ack;
    assign scl_line = !(m_scl_oe || s_scl_oe);
    assign sda_line = !(m_sda_oe || s_sda_oe);
    assign rd_data  = mem[rd_addr];
    rtcs_i2c_slave #(.SLV_ADDR(SLV), .TIMEOUT_CYC(TOUT)) rtcs_i2c_slave_inst (
        .sys_clk_i(sys_clk), .rst_i(rst), .scl_i(scl_line), .scl_o(),
        .scl_oe_o(s_scl_oe), .sda_i(sda_line), .sda_o(), .sda_oe_o(s_sda_oe),
        .rd_addr_o(rd_addr), .rd_data_i(rd_data), .rd_strobe_o(rd_strobe),
        .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data), .busy_o(busy));
    rtcs_master_model rtcs_master_model_inst (.sys_clk_i(sys_clk),
        .scl_i(scl_line), .sda_i(sda_line), .scl_oe_o(m_scl_oe),
        .sda_oe_o(m_sda_oe));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // ----------------------------------------------------------------
    // register file side: random stalls, every pair checked in order
    // ----------------------------------------------------------------
    always @(negedge sys_clk) wr_ready <= !hold && (($urandom % 4) != 0);
    always @(posedge sys_clk) begin
        if (s_scl_oe) stretched = 1'b1;
        if (rd_strobe) n_strobe++;
        if (wr_valid && wr_ready) begin
            `CHK({wr_addr, wr_data}, exp_q.pop_front())
            mem[wr_addr] = wr_data;
        end
    end
    function automatic int nxt(int p);
        if (p >= 'h10 && p <= 'h3F) return (p & 'hF0) | ((p + 1) & 'hF);
        return (p + 1) & 'hFF;
    endfunction
    task automatic settle();
        int n;
        n = 0;
        while ((exp_q.size() != 0 || wr_valid !== 1'b0) && n < 5000) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK(exp_q.size(), 0)
    endtask
    task automatic wr(input int a, input int n);
        logic [7:0] d;
        rtcs_master_model_inst.start();
        rtcs_master_model_inst.put({SLV, 1'b0}, ack);
        `CHK(ack, 1'b1)
        rtcs_master_model_inst.put(a[7:0], ack);
        `CHK(ack, 1'b1)
        ptr = a;
        for (int i = 0; i < n; i++) begin
            d = $urandom;
            exp_q.push_back({ptr[7:0], d});
            rtcs_master_model_inst.put(d, ack);
            `CHK(ack, 1'b1)
            ptr = nxt(ptr);
        end
        rtcs_master_model_inst.stop();
        settle();
        `CHK(rd_addr, ptr[7:0])
    endtask
    // a below zero reads on from the kept pointer
    task automatic rd(input int a, input int n);
        logic [7:0] d;
        int s0;
        s0 = n_strobe;
        rtcs_master_model_inst.start();
        if (a >= 0) begin
            rtcs_master_model_inst.put({SLV, 1'b0}, ack);
            rtcs_master_model_inst.put(a[7:0], ack);
            `CHK(ack, 1'b1)
            ptr = a;
            rtcs_master_model_inst.start();
        end
        rtcs_master_model_inst.put({SLV, 1'b1}, ack);
        `CHK(ack, 1'b1)
        for (int i = 0; i < n; i++) begin
            rtcs_master_model_inst.get(i < n - 1, d);
            `CHK(d, mem[ptr])
            ptr = nxt(ptr);
        end
        rtcs_master_model_inst.stop();
        `CHK(rd_addr, ptr[7:0])
        `CHK(n_strobe - s0, n)
    endtask
    task automatic final_report();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk);
        failures++;
        final_report();
    end
    initial begin
        void'($urandom(59582));
        for (int i = 0; i < 256; i++) mem[i] = $urandom;
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        repeat (5) @(negedge sys_clk);
        `CHK({rd_addr, busy, wr_valid, s_sda_oe, s_scl_oe}, 12'h000)
        wr('h1E, 4);
        hold = 1'b1;
        fork
            begin
                repeat (2500) @(negedge sys_clk);
                hold = 1'b0;
            end
        join_none
        wr('h2E, 16);
        `CHK(stretched, 1'b1)
        rd('h3E, 3);
        rd(-1, 2);
        rtcs_master_model_inst.start();
        rtcs_master_model_inst.put({SLV ^ 7'h01, 1'b0}, ack);
        `CHK(ack, 1'b0)
        rtcs_master_model_inst.put(8'h20, ack);
        `CHK(ack, 1'b0)
        rtcs_master_model_inst.stop();
        `CHK(rd_addr, ptr[7:0])
        rtcs_master_model_inst.start();
        rtcs_master_model_inst.put({SLV, 1'b0}, ack);
        `CHK(busy, 1'b1)
        repeat (TOUT + 50) @(negedge sys_clk);
        `CHK({busy, s_sda_oe}, 2'h0)
        rtcs_master_model_inst.stop();
        rd(-1, 2);
        `CHK(rtcs_master_model_inst.stuck, 0)
        final_report();
    end
endmodule
`default_nettype wire
